// *** hw/rx_dma_done_queue_cfg.sv ***
// How it works
// RULE1 - 16-bit flush timer, decrement every 256 clocks
// RULE2 - done-queue write reloads the flush timer
// RULE3 - timer expiry flushes buffered descriptors
// RULE4 - timer setting resets to zero, illegal
// RULE5 - host programs nonzero timer before enabling
// RULE6 - setting 1 reloads 1, FFFF reloads 65536
// RULE7 - burst enable bit 4: burst or single
// RULE8 - flush bit 5 pushes out buffered descriptors
// RULE9 - written flag after 2^threshold descriptors
// RULE10 - 768-dword RAM, three per channel
// RULE11 - host writes only dword 2 lower half
// RULE12 - bit 0 enables the receive channel
// RULE13 - buffer size mode plus first-buffer flag
// RULE14 - 4-bit first-buffer data offset
// RULE15 - buffer threshold schedules done-queue posts
// RULE16 - 3-bit filled-buffer count in bits 29-31
// RULE17 - 13-bit byte count in bits 16-28
// RULE18 - buffer address and descriptor offsets per channel
// RULE19 - bits 10-14 reserved, host writes zero
// RULE20 - 8-bit selector picks channel 1 to 256
// RULE21 - word select: six halves, only 100 writable
// RULE22 - direction one reads, busy until data valid
// RULE23 - direction zero writes data register, busy clears
// RULE24 - read-only busy flag at select bit 15
// RULE25 - burst write once six descriptors buffered
// RULE26 - no room raises overflow flag, no write
// RULE27 - host waits for busy clear
// RULE28 - writes to read-only word codes are ignored
`timescale 1ns/100ps
module rx_dma_done_queue_cfg #(
	parameter int CHANNELS = 256,
	parameter int DIVIDE = rx_dma_cfg_pkg::timer_prescale
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive data path: descriptor completed for the done queue
	input wire logic desc_valid,
	input wire logic [31:0] desc_data,
	// done queue room in memory, in descriptors, from pointer logic
	input wire logic [15:0] queue_room,
	// receive data path updates of a channel's dma-owned state
	input wire logic dma_upd_valid,
	input wire logic [7:0] dma_upd_chan,
	input wire logic [31:0] dma_upd_dword0,
	input wire logic [31:0] dma_upd_dword1,
	input wire logic [15:0] dma_upd_dword2_hi,
	input wire logic dma_upd_first_buf,
	// done queue writer in memory
	output logic dq_write_valid,
	output logic [31:0] dq_write_data,
	output logic dq_burst,
	output logic desc_ready
);
	localparam int depth = rx_dma_cfg_pkg::fifo_depth;

	typedef enum logic [1:0] {idle_s, read_s, write_s, done_s} ind_state_t;

	// per-channel config storage [RULE10] [RULE18]
	logic [31:0] dword0_mem [CHANNELS];
	logic [31:0] dword1_mem [CHANNELS];
	logic [31:0] dword2_mem [CHANNELS];

	logic [15:0] timer_setting_reg;
	logic [15:0] queue_ctrl_reg;
	logic [15:0] select_reg;
	logic [15:0] data_reg;
	logic [16:0] timer_reg;
	logic written_flag_reg;
	logic overflow_flag_reg;
	logic [7:0] written_count_reg;
	logic [31:0] fifo_mem [depth];
	logic [$clog2(depth)-1:0] wr_ptr_reg;
	logic [$clog2(depth)-1:0] rd_ptr_reg;
	logic [$clog2(depth):0] fill_reg;
	logic draining_reg;
	ind_state_t ind_state_reg;
	logic [31:0] read_word;

	logic bus_write;
	logic bus_read;
	logic tick;
	logic burst_on;
	logic flush_req;
	logic timer_expired;
	logic pop;
	logic push;
	logic status_clear;
	logic [2:0] word_sel;
	logic [7:0] chan_sel;
	logic draining_next;
	logic [$clog2(depth):0] fill_next;

	function automatic logic [15:0] half_of(input logic [31:0] d, input logic upper);
		half_of = upper ? d[31:16] : d[15:0];
	endfunction : half_of

	function automatic logic [7:0] status_goal(input logic [2:0] code);
		status_goal = 8'h01 << code;
	endfunction : status_goal

	// a setting of n loads n ticks, except all ones, which loads one more so the top
	// setting spans 65536 ticks; an illegal zero loads one tick so the timer cannot stick
	function automatic logic [16:0] reload_count(input logic [15:0] setting);
		if (setting == 16'h0000)
			reload_count = 17'h00001;
		else if (setting == 16'hffff)
			reload_count = 17'h10000;
		else
			reload_count = {1'b0, setting};
	endfunction : reload_count

	assign bus_write = psel && penable && pwrite;
	assign bus_read = psel && !penable && !pwrite;
	assign burst_on = queue_ctrl_reg[rx_dma_cfg_pkg::burst_enable_bit];
	assign word_sel = select_reg[rx_dma_cfg_pkg::word_sel_lsb +: 3];
	assign chan_sel = select_reg[7:0];
	assign status_clear = bus_write && paddr == rx_dma_cfg_pkg::dma_status_off;

	// apb slave answers every access in its first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !(paddr == rx_dma_cfg_pkg::flush_timer_off
				|| paddr == rx_dma_cfg_pkg::indirect_select_off
				|| paddr == rx_dma_cfg_pkg::indirect_data_off
				|| paddr == rx_dma_cfg_pkg::queue_control_off
				|| paddr == rx_dma_cfg_pkg::dma_status_off
				|| paddr == rx_dma_cfg_pkg::written_count_off);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (bus_read) begin
			case (paddr)
				rx_dma_cfg_pkg::flush_timer_off: prdata <= {16'h0000, timer_setting_reg};
				rx_dma_cfg_pkg::indirect_select_off: prdata <= {16'h0000, select_reg};
				rx_dma_cfg_pkg::indirect_data_off: prdata <= {16'h0000, data_reg};
				rx_dma_cfg_pkg::queue_control_off: prdata <= {16'h0000, queue_ctrl_reg};
				rx_dma_cfg_pkg::dma_status_off:
					prdata <= {30'h0, overflow_flag_reg, written_flag_reg};
				rx_dma_cfg_pkg::written_count_off: prdata <= {24'h0, written_count_reg};
				default: prdata <= '0;
			endcase
		end
	end

	// host control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_setting_reg <= rx_dma_cfg_pkg::reset_zero; // [RULE4]
			queue_ctrl_reg <= rx_dma_cfg_pkg::reset_zero;
		end else if (bus_write) begin
			if (paddr == rx_dma_cfg_pkg::flush_timer_off)
				timer_setting_reg <= pwdata[15:0];
			if (paddr == rx_dma_cfg_pkg::queue_control_off)
				queue_ctrl_reg <= pwdata[15:0] & rx_dma_cfg_pkg::queue_control_mask;
		end
	end

	// flush timer prescaler runs only while bursting is enabled [RULE1]
	tick_divider #(
		.DIVIDE(DIVIDE)
	) prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.run(burst_on),
		.tick(tick)
	);

	// expiry comes as many ticks after a reload as the loaded count [RULE6]
	assign timer_expired = burst_on && timer_reg == 17'h00000;
	assign flush_req = queue_ctrl_reg[rx_dma_cfg_pkg::fifo_flush_bit] || timer_expired; // [RULE8] [RULE3]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_reg <= '0;
		end else if (dq_write_valid || !burst_on || timer_expired) begin
			timer_reg <= reload_count(timer_setting_reg); // [RULE2] [RULE6]
		end else if (tick) begin
			timer_reg <= timer_reg - 17'h1; // [RULE1]
		end
	end

	// descriptor fifo; single mode passes one descriptor at a time [RULE7]
	// ready leaves a flop fed from next-state values, so it matches a decode of the
	// current fifo state without a combinational path to the pin
	assign fill_next = fill_reg + ($bits(fill_reg))'(push) - ($bits(fill_reg))'(pop);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_ready <= 1'b0;
		end else begin
			desc_ready <= fill_next != ($clog2(depth)+1)'(depth) && !draining_next;
		end
	end
	assign push = desc_valid && desc_ready;
	assign pop = draining_reg && fill_reg != '0 && queue_room != 16'h0000;

	always_ff @(posedge pclk) begin
		if (push)
			fifo_mem[wr_ptr_reg] <= desc_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			fill_reg <= fill_next;
		end
	end

	// drain decision: high water or flush in burst mode, any entry otherwise
	always_comb begin
		draining_next = draining_reg;
		if (draining_reg) begin
			// stop when empty or memory queue has no more room
			if (fill_reg == '0 || (fill_reg == 1 && pop)
				|| queue_room == 16'h0000 || (queue_room == 16'h0001 && pop))
				draining_next = 1'b0;
		end else if (fill_reg != '0) begin
			if (!burst_on || flush_req
				|| fill_reg >= ($clog2(depth)+1)'(rx_dma_cfg_pkg::fifo_high_water))
				draining_next = 1'b1; // [RULE25] [RULE7]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			draining_reg <= 1'b0;
		end else begin
			draining_reg <= draining_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_write_valid <= 1'b0;
			dq_write_data <= '0;
			dq_burst <= 1'b0;
		end else begin
			dq_write_valid <= pop;
			dq_write_data <= fifo_mem[rd_ptr_reg];
			dq_burst <= burst_on;
		end
	end

	// status flags: set beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			written_flag_reg <= 1'b0;
			overflow_flag_reg <= 1'b0;
			written_count_reg <= '0;
		end else begin
			if (draining_reg && fill_reg != '0 && queue_room == 16'h0000)
				overflow_flag_reg <= 1'b1; // [RULE26]
			else if (status_clear && pwdata[1])
				overflow_flag_reg <= 1'b0;
			if (pop && written_count_reg + 8'h01
				>= status_goal(queue_ctrl_reg[rx_dma_cfg_pkg::status_thr_lsb +: 3])) begin
				written_flag_reg <= 1'b1; // [RULE9]
				written_count_reg <= '0;
			end else begin
				if (pop)
					written_count_reg <= written_count_reg + 8'h01;
				if (status_clear && pwdata[0])
					written_flag_reg <= 1'b0;
			end
		end
	end

	// indirect access sequencer [RULE22] [RULE23] [RULE24]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_state_reg <= idle_s;
			select_reg <= rx_dma_cfg_pkg::reset_zero;
		end else begin
			case (ind_state_reg)
				idle_s: begin
					if (bus_write && paddr == rx_dma_cfg_pkg::indirect_select_off) begin
						select_reg <= (pwdata[15:0] & rx_dma_cfg_pkg::select_mask)
							| (16'h0001 << rx_dma_cfg_pkg::busy_bit); // [RULE20] [RULE24]
						ind_state_reg <= pwdata[rx_dma_cfg_pkg::direction_bit] ? read_s : write_s;
					end
				end
				read_s: ind_state_reg <= done_s;
				write_s: ind_state_reg <= done_s;
				done_s: begin
					select_reg[rx_dma_cfg_pkg::busy_bit] <= 1'b0;
					ind_state_reg <= idle_s;
				end
				default: ind_state_reg <= idle_s;
			endcase
		end
	end

	// pick the dword that holds the addressed half word [RULE21]
	always_comb begin
		case (word_sel[2:1])
			2'b00: read_word = dword0_mem[chan_sel];
			2'b01: read_word = dword1_mem[chan_sel];
			2'b10: read_word = dword2_mem[chan_sel];
			default: read_word = '0;
		endcase
	end

	// data register: host writes only while idle, read result lands on done [RULE27]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_reg <= rx_dma_cfg_pkg::reset_zero;
		end else if (ind_state_reg == read_s) begin
			data_reg <= (word_sel <= rx_dma_cfg_pkg::last_valid_word)
				? half_of(read_word, word_sel[0]) : 16'h0000; // [RULE22]
		end else if (bus_write && paddr == rx_dma_cfg_pkg::indirect_data_off
			&& ind_state_reg == idle_s) begin
			data_reg <= pwdata[15:0];
		end
	end

	// config ram: host owns dword 2 low bits 0-9, the dma dwords 0-1, dword 2 bit 15 and upper half
	// host write while dma updates same channel: host field wins for its own bits
	always_ff @(posedge pclk) begin
		if (dma_upd_valid) begin
			dword0_mem[dma_upd_chan] <= dma_upd_dword0; // [RULE18]
			dword1_mem[dma_upd_chan] <= dma_upd_dword1; // [RULE18]
			dword2_mem[dma_upd_chan][31:16] <= dma_upd_dword2_hi; // [RULE16] [RULE17]
			dword2_mem[dma_upd_chan][rx_dma_cfg_pkg::first_buf_bit] <= dma_upd_first_buf; // [RULE13]
		end
		if (ind_state_reg == write_s && word_sel == rx_dma_cfg_pkg::host_writable_word) begin
			// channel on, buffer size, offset and threshold only [RULE11] [RULE12] [RULE13]
			// [RULE14] [RULE15] [RULE19] [RULE28]
			dword2_mem[chan_sel][9:0] <= data_reg[9:0];
		end
	end
endmodule : rx_dma_done_queue_cfg

// *** hw/rx_dma_cfg_pkg.sv ***
package rx_dma_cfg_pkg;
	// register byte offsets
	localparam logic [11:0] flush_timer_off = 12'h744;
	localparam logic [11:0] indirect_select_off = 12'h770;
	localparam logic [11:0] indirect_data_off = 12'h774;
	localparam logic [11:0] queue_control_off = 12'h780;
	localparam logic [11:0] dma_status_off = 12'h784;
	localparam logic [11:0] written_count_off = 12'h788;
	// queue control fields
	localparam int burst_enable_bit = 4;
	localparam int fifo_flush_bit = 5;
	localparam int status_thr_lsb = 8;
	localparam logic [15:0] queue_control_mask = 16'h073f;
	// indirect select fields
	localparam int busy_bit = 15;
	localparam int direction_bit = 14;
	localparam int word_sel_lsb = 8;
	localparam logic [15:0] select_mask = 16'h47ff;
	// dword 2 lower word fields
	localparam int chan_on_bit = 0;
	localparam int buf_size_lsb = 1;
	localparam int buf_offset_lsb = 3;
	localparam int buf_thr_lsb = 7;
	localparam int first_buf_bit = 15;
	localparam logic [15:0] host_word_mask = 16'h03ff;
	// dword 2 upper word fields
	localparam int byte_count_lsb = 16;
	localparam int thr_count_lsb = 29;
	// word select codes
	localparam logic [2:0] host_writable_word = 3'h4;
	localparam logic [2:0] last_valid_word = 3'h5;
	// timing and sizes
	localparam int timer_prescale = 256;
	localparam int fifo_depth = 8;
	localparam int fifo_high_water = 6;
	localparam int ram_dwords_per_chan = 3;
	localparam logic [15:0] reset_zero = 16'h0000;
endpackage : rx_dma_cfg_pkg

// *** hw/tick_divider.sv ***
`timescale 1ns/100ps
// one-cycle enable every DIVIDE clocks while run is high
module tick_divider #(
	parameter int DIVIDE = 256
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic tick
);
	logic [$clog2(DIVIDE)-1:0] count_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			count_reg <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (count_reg == $bits(count_reg)'(DIVIDE - 1));
			count_reg <= (count_reg == $bits(count_reg)'(DIVIDE - 1)) ? '0 : count_reg + 1'b1;
		end
	end
endmodule : tick_divider

// *** verif/rx_dma_done_queue_cfg_props.sv ***
`timescale 1ns/100ps
module rx_dma_done_queue_cfg_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic desc_valid,
	input wire logic desc_ready,
	input wire logic [15:0] queue_room,
	input wire logic dq_write_valid,
	input wire logic dq_burst
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] timer_reg;
	logic [15:0] ctrl_reg;
	logic wr_done;
	logic rd_done;
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite;
	// shadows of the two plain read-write registers, reset like the design
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_reg <= 16'h0000;
			ctrl_reg <= 16'h0000;
		end else if (wr_done && paddr == 12'h744) begin
			timer_reg <= pwdata[15:0];
		end else if (wr_done && paddr == 12'h780) begin
			ctrl_reg <= pwdata[15:0] & 16'h073f;
		end
	end
	a_burst_follows_bit: assert property (wr_done && paddr == 12'h780 |-> ##2
		dq_burst == $past(pwdata[4], 2)) else $error("burst output differs from control bit");
	a_single_drain: assert property (!dq_burst && desc_valid && desc_ready &&
		queue_room != 16'h0000 |-> ##[1:12] dq_write_valid) else $error("single write missing");
	a_timer_readback: assert property (rd_done && paddr == 12'h744 |->
		prdata == {16'h0000, timer_reg}) else $error("flush timer read wrong");
	a_ctrl_readback: assert property (rd_done && paddr == 12'h780 |->
		prdata == {16'h0000, ctrl_reg}) else $error("queue control read wrong");
	a_busy_on_start: assert property (wr_done && paddr == 12'h770 ##2
		(psel && !penable && !pwrite && paddr == 12'h770) |=> prdata[15])
		else $error("busy flag not set after start");
	a_no_room_hold: assert property ($past(queue_room) == 16'h0000 |-> !dq_write_valid)
		else $error("write with no room");
	a_answer_next: assert property (psel && !penable |=> pready)
		else $error("register answer late");
	a_indirect_width: assert property (rd_done && (paddr == 12'h770 || paddr == 12'h774)
		|-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
	cover property (dq_write_valid && dq_burst);
	cover property (rd_done && prdata[15]);
	cover property (desc_valid && !desc_ready);
endmodule : rx_dma_done_queue_cfg_props
bind rx_dma_done_queue_cfg rx_dma_done_queue_cfg_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .desc_valid(desc_valid), .desc_ready(desc_ready),
	.queue_room(queue_room), .dq_write_valid(dq_write_valid), .dq_burst(dq_burst));

// *** verif/rx_path_model.sv ***
`timescale 1ns/100ps
module rx_path_model (
	input wire logic pclk,
	input wire logic desc_ready,
	input wire logic dq_write_valid,
	input wire logic [31:0] dq_write_data,
	output logic desc_valid,
	output logic [31:0] desc_data
);
	int writes = 0;
	logic [31:0] last_out;
	initial desc_valid = 1'b0;
	initial desc_data = 32'h0;
	always @(posedge pclk) begin
		if (dq_write_valid === 1'b1) begin
			writes++;
			last_out = dq_write_data;
		end
	end
	// data is inverted when idle so a stale word never looks like a fresh one
	task automatic offer(input logic [31:0] d, output logic ok);
		ok = 1'b0;
		desc_valid <= 1'b1;
		desc_data <= d;
		for (int k = 0; k < 32 && !ok; k++) begin
			@(posedge pclk);
			ok = (desc_ready === 1'b1);
		end
		desc_valid <= 1'b0;
		desc_data <= ~d;
		@(posedge pclk);
	endtask : offer
endmodule : rx_path_model

// *** verif/rx_dma_done_queue_cfg_tb.sv ***
`timescale 1ns/100ps
module rx_dma_done_queue_cfg_tb;
	localparam int tick_div = 4;
	localparam logic [11:0] tmr = rx_dma_cfg_pkg::flush_timer_off;
	localparam logic [11:0] sel = rx_dma_cfg_pkg::indirect_select_off;
	localparam logic [11:0] dat = rx_dma_cfg_pkg::indirect_data_off;
	localparam logic [11:0] ctl = rx_dma_cfg_pkg::queue_control_off;
	localparam logic [11:0] sts = rx_dma_cfg_pkg::dma_status_off;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, upd = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, desc_data, dq_write_data, rv;
	logic pready, pslverr, desc_valid, dq_write_valid, dq_burst, desc_ready, ev, ok;
	logic [15:0] queue_room = 16'h0010;
	logic [15:0] ex [8] = '{16'h9bdf, 16'h1357, 16'hace0, 16'h2468, 16'h83ff, 16'hfedc, 0, 0};
	int tv [2] = '{1, 16};
	int bad_count = 0, tests_run = 0, w0, t0, cyc;
	always #5 pclk = ~pclk;
	rx_dma_done_queue_cfg #(.DIVIDE(tick_div)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .desc_valid(desc_valid), .desc_data(desc_data),
		.queue_room(queue_room), .dma_upd_valid(upd), .dma_upd_chan(8'hff),
		.dma_upd_dword0(32'h1357_9bdf), .dma_upd_dword1(32'h2468_ace0),
		.dma_upd_dword2_hi(16'hfedc), .dma_upd_first_buf(1'b1), .dq_write_valid(dq_write_valid),
		.dq_write_data(dq_write_data), .dq_burst(dq_burst), .desc_ready(desc_ready));
	rx_path_model pm (.pclk(pclk), .desc_ready(desc_ready), .dq_write_valid(dq_write_valid),
		.dq_write_data(dq_write_data), .desc_valid(desc_valid), .desc_data(desc_data));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// pready and the answer are taken at the rising edge that samples the access phase
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic seen;
		seen = 1'b0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int k = 0; k < 16 && !seen; k++) begin
			@(posedge pclk);
			seen = (pready === 1'b1);
			rv = prdata;
			ev = pslverr;
		end
		chk("answer", 32'h1, 32'(seen));
		if (!seen) complete_run();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdm(input logic [11:0] a, input logic [31:0] m, e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rv & m);
	endtask : rdm
	task automatic ind(input logic rd, input logic [2:0] w, input logic [7:0] ch);
		wr(sel, {17'h0, rd, 3'h0, w, ch});
		rdm(sel, 32'h8000, 32'h8000, "busy");
		for (int k = 0; k < 8 && rv[15] !== 1'b0; k++) begin
			apb(1'b0, sel, 32'h0);
		end
		chk("busy end", 32'h0, rv & 32'h8000);
	endtask : ind
	task automatic send(input int cnt, input logic [31:0] base);
		for (int i = 0; i < cnt; i++) begin
			pm.offer(base + 32'(i), ok);
			chk("accept", 32'h1, 32'(ok));
		end
	endtask : send
	task automatic wait_out(input int target);
		for (int k = 0; k < 200 && pm.writes < target; k++) begin
			@(posedge pclk);
		end
		chk("writes", 32'(target), 32'(pm.writes));
		if (pm.writes < target) complete_run();
	endtask : wait_out
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdm(tmr, 32'hffffffff, 32'h0, "timer reset");
		rdm(ctl, 32'hffffffff, 32'h0, "ctrl reset");
		rdm(sel, 32'hffffffff, 32'h0, "select reset");
		apb(1'b0, 12'h7f0, 32'h0);
		chk("unmapped", 32'h1, 32'(ev));
		wr(tmr, 32'hffff);
		rdm(tmr, 32'hffffffff, 32'hffff, "timer");
		wr(ctl, 32'hffff);
		rdm(ctl, 32'hffffffff, 32'h073f, "ctrl");
		wr(ctl, 32'h0200);
		wr(sts, 32'h3);
		w0 = pm.writes;
		send(3, 32'h100);
		wait_out(w0 + 3);
		rdm(sts, 32'h1, 32'h0, "written early");
		send(1, 32'h103);
		wait_out(w0 + 4);
		chk("out data", 32'h103, pm.last_out);
		rdm(sts, 32'h1, 32'h1, "written");
		wr(ctl, 32'h0010);
		send(5, 32'h200);
		repeat (20) @(posedge pclk);
		chk("held", 32'(w0 + 4), 32'(pm.writes));
		send(1, 32'h205);
		wait_out(w0 + 10);
		chk("burst out", 32'h1, 32'(dq_burst));
		chk("burst order", 32'h205, pm.last_out);
		send(2, 32'h300);
		repeat (20) @(posedge pclk);
		chk("flush held", 32'(w0 + 10), 32'(pm.writes));
		wr(ctl, 32'h0030);
		wait_out(w0 + 12);
		wr(ctl, 32'h0010);
		queue_room <= 16'h0;
		send(1, 32'h400);
		wr(ctl, 32'h0030);
		repeat (10) @(posedge pclk);
		chk("no room", 32'(w0 + 12), 32'(pm.writes));
		rdm(sts, 32'h2, 32'h2, "overflow");
		wr(ctl, 32'h0);
		queue_room <= 16'h10;
		wait_out(w0 + 13);
		foreach (tv[i]) begin
			wr(tmr, 32'(tv[i]));
			wr(ctl, 32'h0010);
			t0 = int'($time);
			send(1, 32'h500);
			wait_out(w0 + 14 + i);
			cyc = (int'($time) - t0) / 10;
			chk("expiry", 1, 32'(cyc >= (tv[i] - 1) * tick_div && cyc <= (tv[i] + 1) * tick_div + 12));
			wr(ctl, 32'h0);
		end
		upd <= 1'b1;
		@(posedge pclk);
		upd <= 1'b0;
		wr(dat, 32'h03ff);
		ind(1'b0, 3'h4, 8'hff);
		wr(dat, 32'h0155);
		ind(1'b0, 3'h4, 8'h00);
		wr(dat, 32'h1234);
		ind(1'b0, 3'h0, 8'hff);
		for (int k = 0; k < 8; k++) begin
			ind(1'b1, 3'(k), 8'hff);
			rdm(dat, (k == 4) ? 32'h83ff : 32'hffffffff, {16'h0, ex[k]}, "ram word");
		end
		ind(1'b1, 3'h4, 8'h00);
		rdm(dat, 32'h03ff, 32'h0155, "chan zero");
		complete_run();
	end
endmodule : rx_dma_done_queue_cfg_tb
